// ---- dout_mapper_consts.vh ----
// Constants for the digital output sensor mapper.
`ifndef DOUT_MAPPER_CONSTS_VH
`define DOUT_MAPPER_CONSTS_VH
`define OFS_CONFIG        12'h000
`define OFS_VALUE         12'h004
`define OFS_SCALE_LOW     12'h008
`define OFS_SCALE_HIGH    12'h00c
`define OFS_SENSOR0       12'h010
`define OFS_STATUS        12'h020
`define CFG_TYPE_LSB      8
`define CFG_MAP_LSB       12
`define CFG_SRANGE_BIT    5
`define CFG_RESET         16'h0000
`define TYPE_NULL         2'h0
`define TYPE_ONOFF        2'h1
`define TYPE_PWM          2'h2
`define TYPE_SERVO        2'h3
`define MAP_NONE          3'h0
`define PERIOD_NS         20
`define FRAME_US          20000
`define FRAME_CYC         ((`FRAME_US * 1000) / `PERIOD_NS)
`define PULSE_0P5_US      500
`define PULSE_1P0_US      1000
`define PULSE_2P0_US      2000
`define PULSE_2P5_US      2500
`define US_CYC            (1000 / `PERIOD_NS)
`define PWM_STEPS         100
`endif

// ---- dout_mapper.v ----
// Digital output stage that maps a sensor value or a set percentage to on/off, PWM or servo output.
//
// Behaviour
// - A source field selects no sensor or one of sensors zero to three.
// - With no sensor selected the output follows a 0 to 100 percent value.
// - With a sensor selected and mapping supported the output tracks it.
// - Mapped PWM is 0 percent at or below low and 100 percent at or above high.
// - Mapped servo is minimum pulse at or below low and maximum at or above.
// - Servo range zero spans 1.0 to 2.0 ms and range one spans 0.5 to 2.5 ms.
// - With the mapping capability bit clear the source selection is ignored.
// - Output type 0 is null, 1 on/off, 2 PWM and 3 servo.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "dout_mapper_consts.vh"
module dout_mapper #(
  parameter [31:0] FRAME_CYC = `FRAME_CYC,
  parameter        MAP_CAPABLE = 1'b1
)
(
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         dout_o,
  output reg         dout_oe_o,
  output reg  [6:0]  level_pct_o
);

  reg  [15:0] config_r;
  reg  [6:0]  value_r;
  reg  [15:0] scale_low_r;
  reg  [15:0] scale_high_r;
  reg  [15:0] sensor_r [0:3];
  reg  [31:0] frame_cnt_r;
  reg  [6:0]  pct_r;
  reg  [15:0] sel_val;
  reg  [31:0] num;
  reg  [31:0] span;
  reg  [6:0]  pct_nxt;
  reg  [31:0] high_cyc;
  reg  [31:0] min_us;
  reg  [31:0] width_us;
  reg  [31:0] quot;
  reg  [31:0] rd_nxt;
  reg  [31:0] duty_r;
  wire [1:0]  out_type;
  wire [2:0]  map_sel;
  wire        mapped;
  wire        access;
  wire        addr_ok;
  wire        wr_hit;
  wire        rd_hit;
  genvar      g;

  // Sensor registers occupy four consecutive words.
  function is_sensor;
    input [11:0] a;
    begin
      is_sensor = (a[11:4] == `OFS_SENSOR0 >> 4) && (a[1:0] == 2'b00);
    end
  endfunction

  // The whole word is compared, so a large value clamps instead of wrapping.
  function [6:0] clamp_pct;
    input [31:0] d;
    begin
      if (d > 32'd100)
        clamp_pct = 7'd100;
      else
        clamp_pct = d[6:0];
    end
  endfunction

  assign out_type = config_r[`CFG_TYPE_LSB +: 2];
  assign map_sel  = config_r[`CFG_MAP_LSB +: 3];
  assign mapped   = MAP_CAPABLE && (map_sel != `MAP_NONE);
  assign access   = psel_i && penable_i;
  assign addr_ok  = (paddr_i == `OFS_CONFIG) || (paddr_i == `OFS_VALUE) ||
                    (paddr_i == `OFS_SCALE_LOW) ||
                    (paddr_i == `OFS_SCALE_HIGH) ||
                    (paddr_i == `OFS_STATUS) || is_sensor(paddr_i);

  // A write lands on the completing edge, while the master still holds
  // address and data, so a stalled access never changes a register early.
  assign wr_hit = access && pready_o && pwrite_i;
  assign rd_hit = access && !pready_o && !pwrite_i;

  // One wait state keeps the answer registered rather than combinational.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= access && !pready_o;
      pslverr_o <= access && !pready_o && !addr_ok;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      config_r <= `CFG_RESET;
    else if (wr_hit && paddr_i == `OFS_CONFIG)
      config_r <= pwdata_i[15:0];
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      value_r <= 7'h00;
    else if (wr_hit && paddr_i == `OFS_VALUE)
      value_r <= clamp_pct(pwdata_i);
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      scale_low_r <= 16'h0000;
    else if (wr_hit && paddr_i == `OFS_SCALE_LOW)
      scale_low_r <= pwdata_i[15:0];
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      scale_high_r <= 16'hffff;
    else if (wr_hit && paddr_i == `OFS_SCALE_HIGH)
      scale_high_r <= pwdata_i[15:0];
  end

  // Sensor words are written by software, standing in for the measurements.
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : sens
      always @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          sensor_r[g] <= 16'h0000;
        else if (wr_hit && is_sensor(paddr_i) && paddr_i[3:2] == g)
          sensor_r[g] <= pwdata_i[15:0];
      end
    end
  endgenerate

  // Unmapped addresses read as zero.
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
      `OFS_CONFIG:     rd_nxt = {16'h0000, config_r[15:12],
                                 MAP_CAPABLE[0], config_r[10:0]};
      `OFS_VALUE:      rd_nxt = {25'h0, value_r};
      `OFS_SCALE_LOW:  rd_nxt = {16'h0000, scale_low_r};
      `OFS_SCALE_HIGH: rd_nxt = {16'h0000, scale_high_r};
      `OFS_STATUS:     rd_nxt = {25'h0, pct_r};
      default:
      begin
        if (is_sensor(paddr_i))
          rd_nxt = {16'h0000, sensor_r[paddr_i[3:2]]};
      end
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      prdata_o <= 32'h0000_0000;
    else if (rd_hit)
      prdata_o <= rd_nxt;
  end

  // Percent is computed once per input change; a divider truncates it toward zero.
  always @*
  begin
    sel_val = sensor_r[map_sel[1:0] - 2'd1];
    num     = 32'h0;
    span    = 32'h1;
    quot    = 32'h0;
    if (!mapped)
      pct_nxt = value_r;
    else if (sel_val <= scale_low_r)
      pct_nxt = 7'd0;
    else if (sel_val >= scale_high_r)
      pct_nxt = 7'd100;
    else
    begin
      num     = {16'h0, sel_val - scale_low_r} * `PWM_STEPS;
      span    = {16'h0, scale_high_r - scale_low_r};
      quot    = num / span;
      pct_nxt = quot[6:0];
    end
  end

  // Servo width spans the selected range linearly with the percentage.
  always @*
  begin
    if (config_r[`CFG_SRANGE_BIT])
    begin
      min_us   = `PULSE_0P5_US;
      width_us = `PULSE_2P5_US - `PULSE_0P5_US;
    end
    else
    begin
      min_us   = `PULSE_1P0_US;
      width_us = `PULSE_2P0_US - `PULSE_1P0_US;
    end
  end

  always @*
  begin
    if (out_type == `TYPE_SERVO)
      high_cyc = (min_us + (width_us * pct_r) / 100) * `US_CYC;
    else
      high_cyc = (FRAME_CYC / 100) * pct_r;
  end

  // The high time is taken only at a frame boundary, so a change in the
  // middle of a frame never yields a runt or a doubled pulse.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      duty_r <= 32'h0;
    else if (frame_cnt_r >= FRAME_CYC - 1)
      duty_r <= high_cyc;
  end

  // One frame counter serves PWM and servo; on/off ignores it.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      frame_cnt_r <= 32'h0;
    else if (frame_cnt_r >= FRAME_CYC - 1)
      frame_cnt_r <= 32'h0;
    else
      frame_cnt_r <= frame_cnt_r + 32'h1;
  end

  // The reported level trails the internal percentage by one register.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pct_r       <= 7'h00;
      level_pct_o <= 7'h00;
    end
    else
    begin
      pct_r       <= pct_nxt;
      level_pct_o <= pct_r;
    end
  end

  // Null leaves the pin released; every other type drives it.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      dout_o    <= 1'b0;
      dout_oe_o <= 1'b0;
    end
    else
    begin
      case (out_type)
        `TYPE_NULL:
        begin
          dout_o    <= 1'b0;
          dout_oe_o <= 1'b0;
        end
        `TYPE_ONOFF:
        begin
          dout_o    <= (pct_r != 7'd0);
          dout_oe_o <= 1'b1;
        end
        default:
        begin
          dout_o    <= (frame_cnt_r < duty_r);
          dout_oe_o <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ---- dout_mapper_properties.sv ----
// Checker for the bus handshake and output level of the mapper.
`timescale 1ns/1ns
module dout_mapper_properties (
  input wire        core_clk_i,
  input wire        sys_rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [6:0]  level_pct_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence req_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence bad_s;
    pready_o && paddr_i > 12'h020;
  endsequence
  AST_RDY: assert property (req_s |=> pready_o) else $error("no answer");
  AST_ONE: assert property (pready_o |=> !pready_o) else $error("long ready");
  AST_IDLE: assert property (!psel_i |=> !pready_o) else $error("stray ready");
  AST_SLV: assert property (bad_s |-> pslverr_o) else $error("no error");
  AST_OK: assert property (pready_o && !paddr_i[11:6] && !paddr_i[1:0]
    && paddr_i <= 12'h020 |-> !pslverr_o) else $error("false error");
  AST_RD0: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("error read not zero");
  AST_HOLD: assert property (!pready_o |-> $stable(prdata_o))
    else $error("read data moved");
  AST_PCT: assert property (level_pct_o <= 7'h64) else $error("level high");
endmodule
bind dout_mapper dout_mapper_properties chk_u (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .level_pct_o(level_pct_o));

// ---- dout_load_model.sv ----
// Load model that times the high pulses of the digital output.
`timescale 1ns/1ns
module dout_load_model (
  input  wire        core_clk_i,
  input  wire        dout_i,
  input  wire        dout_oe_i,
  output reg  [31:0] width_o = 32'h0,
  output reg  [7:0]  pulses_o = 8'h0
);
  reg [31:0] cnt_r = 32'h0;
  // A released pin reads low here, as if the load pulled it down.
  always @(posedge core_clk_i)
  begin
    cnt_r <= (dout_i && dout_oe_i) ? cnt_r + 32'h1 : 32'h0;
    if (cnt_r != 32'h0 && !(dout_i && dout_oe_i))
    begin
      width_o <= cnt_r;
      pulses_o <= pulses_o + 8'h1;
    end
  end
endmodule

// ---- test_dout_mapper.sv ----
// Self-checking bench for the digital output mapper.
`timescale 1ns/1ns
module test_dout_mapper;
  reg         core_clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg         psel_i = 1'b0;
  reg         penable_i = 1'b0;
  reg         pwrite_i = 1'b0;
  reg  [11:0] paddr_i = 12'h000;
  reg  [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o, width_w;
  wire        pready_o, pslverr_o, dout_o, dout_oe_o;
  wire [6:0]  level_pct_o;
  wire [7:0]  pulses_w;
  reg  [31:0] rd_r;
  reg         err_r;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i, j, k;
  always #10 core_clk_i = ~core_clk_i;
  dout_mapper #(.FRAME_CYC(32'd1000)) dut_u (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .level_pct_o(level_pct_o));
  dout_load_model load_u (.core_clk_i(core_clk_i), .dout_i(dout_o),
    .dout_oe_i(dout_oe_o), .width_o(width_w), .pulses_o(pulses_w));
  task complete_run;
  begin
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task chk(input [47:0] nm, input [31:0] exp, input [31:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k = k + 1;
    end while (pready_o !== 1'b1 && k < 20);
    if (k == 20)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
    rd_r = prdata_o;
    err_r = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  end
  endtask
  task t_reset;
  begin
    apb(1'b0, 12'h00c, 32'h0);
    chk("high", 32'h0000ffff, rd_r);
    apb(1'b0, 12'h000, 32'h0);
    chk("config", 32'h00000800, rd_r);
  end
  endtask
  task t_direct;
  begin
    apb(1'b1, 12'h000, 32'h00000200);
    apb(1'b1, 12'h004, 32'h00000032);
    apb(1'b0, 12'h020, 32'h0);
    chk("status", 32'h00000032, rd_r);
    j = pulses_w + 2;
    for (k = 0; k < 3000 && pulses_w != j[7:0]; k = k + 1)
      @(posedge core_clk_i);
    chk("width", 32'd500, width_w);
    apb(1'b1, 12'h000, 32'h00000000);
    apb(1'b1, 12'h004, 32'h000000c8);
    chk("oe", 32'h0, {31'h0, dout_oe_o});
    apb(1'b1, 12'h000, 32'h00000100);
    apb(1'b0, 12'h020, 32'h0);
    chk("clamp", 32'h00000064, rd_r);
    chk("onoff", 32'h3, {30'h0, dout_oe_o, dout_o});
  end
  endtask
  task t_map;
  begin
    apb(1'b1, 12'h008, 32'd100);
    apb(1'b1, 12'h00c, 32'd300);
    for (i = 0; i < 4; i = i + 1)
    begin
      // Odd sensors run as servo so both mapped types are exercised.
      apb(1'b1, 12'h000, (i + 1) << 12 | (i[0] ? 32'h300 : 32'h200)
        | (i == 3 ? 32'h20 : 32'h0));
      for (j = 0; j < 3; j = j + 1)
      begin
        apb(1'b1, 12'h010 + 4 * i, 50 + j * 175);
        apb(1'b0, 12'h020, 32'h0);
        chk("mapped", j == 0 ? 0 : j == 1 ? 62 : 100, rd_r);
        chk("level", j == 0 ? 0 : j == 1 ? 62 : 100, {25'h0, level_pct_o});
      end
      apb(1'b1, 12'h010 + 4 * i, 32'd200);
    end
  end
  endtask
  task t_err;
  begin
    apb(1'b0, 12'h024, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_r});
    chk("rdzero", 32'h0, rd_r);
  end
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_direct;
    t_map;
    t_err;
    complete_run;
  end
endmodule
